// ---- hw/dubp_pkg.sv ----
// Shared constants and types for the dual-channel host bus port.
package dubp_pkg;

  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 3;
  localparam int          NUM_REGS      = 8;
  localparam int          DATA_BITS     = 8;

  localparam logic [2:0]  HOLD_IDX       = 3'h0;
  localparam logic [2:0]  INTEN_IDX      = 3'h1;
  localparam logic [2:0]  ALTF_IDX       = 3'h2;
  localparam logic [2:0]  MODEM_IDX      = 3'h4;

  localparam int          ALTF_BCAST_BIT = 0;
  localparam int          INTEN_TXE_BIT  = 1;
  localparam int          MODEM_IR_BIT   = 6;

  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic        SEL_CHAN_A    = 1'b1;
  localparam logic [2:0]  LAST_BIT      = 3'h7;

  localparam int          CLK_PERIOD_PS = 4000;
  localparam int          BIT_TIME_NS   = 64;
  localparam int          BIT_CYCLES    = (BIT_TIME_NS * 1000) / CLK_PERIOD_PS;
  localparam int          IR_CYCLES_RAW = (BIT_CYCLES * 3) / 16;
  localparam int          IR_CYCLES     = (IR_CYCLES_RAW < 1) ? 1 : IR_CYCLES_RAW;

  typedef enum logic [1:0] {
    DUBP_TX_IDLE  = 2'b00,
    DUBP_TX_START = 2'b01,
    DUBP_TX_DATA  = 2'b11,
    DUBP_TX_STOP  = 2'b10
  } dubp_tx_state_t;

endpackage

// ---- hw/dubp_edge.sv ----
// Falling and rising edge detector for one active-low bus strobe.
`timescale 1ns/1ps
module dubp_edge (
  input  wire logic mclk,
  input  wire logic rst_n,
  input  wire logic strobe_n,
  output logic      fall,
  output logic      rise
);
  import dubp_pkg::*;

  logic prev_r;

  // Idle strobe is high, so reset to high to avoid a false edge at release.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      prev_r <= 1'b1;
    end else begin
      prev_r <= strobe_n;
    end
  end

  assign fall = prev_r & ~strobe_n;
  assign rise = ~prev_r & strobe_n;

endmodule

// ---- hw/dubp_chan.sv ----
// One channel: register bank, transmit holding byte, serial shifter and status outputs.
`timescale 1ns/1ps
module dubp_chan #(
  parameter int BIT_CYCLES = dubp_pkg::BIT_CYCLES,
  parameter int IR_CYCLES  = dubp_pkg::IR_CYCLES
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         wr_en,
  input  wire logic [dubp_pkg::ADDR_W-1:0]  wr_addr,
  input  wire logic [dubp_pkg::DATA_W-1:0]  wr_data,
  input  wire logic [dubp_pkg::ADDR_W-1:0]  rd_addr,
  output logic      [dubp_pkg::DATA_W-1:0]  rd_data,
  output logic                              bcast,
  output logic                              irq,
  output logic                              tx_ready_n,
  output logic                              serial_out
);
  import dubp_pkg::*;

  localparam int CW = $clog2(BIT_CYCLES + 1);

  logic [DATA_W-1:0] regs_r [NUM_REGS];
  logic              hold_full_r;
  logic              hold_full_nxt;
  dubp_tx_state_t    state_r;
  dubp_tx_state_t    state_nxt;
  logic [CW-1:0]     baud_r;
  logic [2:0]        bit_r;
  logic [7:0]        shift_r;
  logic              irq_r;
  logic              tx_ready_n_r;
  logic              serial_out_r;

  wire hold_wr  = wr_en && (wr_addr == HOLD_IDX);
  wire load     = (state_r == DUBP_TX_IDLE) && hold_full_r;
  wire bit_tick = (baud_r == CW'(BIT_CYCLES - 1));
  wire ir_mode  = regs_r[MODEM_IDX][MODEM_IR_BIT];
  wire ir_slot  = (baud_r < CW'(IR_CYCLES));
  wire tx_bit   = (state_r == DUBP_TX_START) ? 1'b0 :
                  (state_r == DUBP_TX_DATA)  ? shift_r[0] : 1'b1;
  wire active   = (state_r != DUBP_TX_IDLE);
  // Infrared marks a zero bit with a short high pulse and rests low otherwise.
  wire ir_bit   = active && !tx_bit && ir_slot;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
      always_ff @(posedge mclk) begin
        if (!rst_n) begin
          regs_r[gi] <= REG_RST;
        end else if (wr_en && (wr_addr == ADDR_W'(gi))) begin
          regs_r[gi] <= wr_data;
        end
      end
    end
  endgenerate

  assign rd_data = regs_r[rd_addr];
  assign bcast   = regs_r[ALTF_IDX][ALTF_BCAST_BIT];

  // A new byte written in the cycle the shifter takes the old one keeps the flag set.
  assign hold_full_nxt = hold_wr | (hold_full_r & ~load);

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      DUBP_TX_IDLE: begin
        if (hold_full_r) begin
          state_nxt = DUBP_TX_START;
        end
      end
      DUBP_TX_START: begin
        if (bit_tick) begin
          state_nxt = DUBP_TX_DATA;
        end
      end
      DUBP_TX_DATA: begin
        if (bit_tick && (bit_r == LAST_BIT)) begin
          state_nxt = DUBP_TX_STOP;
        end
      end
      DUBP_TX_STOP: begin
        if (bit_tick) begin
          state_nxt = DUBP_TX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state_r      <= DUBP_TX_IDLE;
      hold_full_r  <= 1'b0;
      baud_r       <= '0;
      bit_r        <= 3'h0;
      shift_r      <= 8'h00;
      irq_r        <= 1'b0;
      tx_ready_n_r <= 1'b0;
      serial_out_r <= 1'b1;
    end else begin
      state_r      <= state_nxt;
      hold_full_r  <= hold_full_nxt;
      baud_r       <= (!active || bit_tick) ? '0 : baud_r + CW'(1);
      if (load) begin
        shift_r <= regs_r[HOLD_IDX];
        bit_r   <= 3'h0;
      end else if (bit_tick && (state_r == DUBP_TX_DATA)) begin
        shift_r <= {1'b0, shift_r[7:1]};
        bit_r   <= bit_r + 3'h1;
      end
      irq_r        <= regs_r[INTEN_IDX][INTEN_TXE_BIT] && !hold_full_r;
      tx_ready_n_r <= hold_full_r;
      serial_out_r <= ir_mode ? ir_bit : tx_bit;
    end
  end

  assign irq        = irq_r;
  assign tx_ready_n = tx_ready_n_r;
  assign serial_out = serial_out_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_reg_store_value: assert property (
    wr_en |=> regs_r[$past(wr_addr)] == $past(wr_data))
    else $error("Written byte did not land in the addressed register.");

  chk_std_idle_high: assert property (
    (!active && !ir_mode) |=> serial_out)
    else $error("Standard mode serial output not high while idle.");

  chk_ir_idle_low: assert property (
    (!active && ir_mode) [*2] |=> !serial_out)
    else $error("Infrared serial output not resting low while idle.");

  chk_std_data_bit: assert property (
    (state_r == DUBP_TX_DATA && !ir_mode) |=> serial_out == $past(shift_r[0]))
    else $error("Standard mode data bit not on serial output.");

  chk_ready_after_hold: assert property (
    hold_wr |=> ##1 tx_ready_n)
    else $error("Transmitter ready did not go inactive after a holding byte write.");

  chk_irq_pending: assert property (
    (regs_r[INTEN_IDX][INTEN_TXE_BIT] && !hold_full_r) [*2] |=> irq)
    else $error("Interrupt not raised while a service request is pending.");

  cov_ir_frame: cover property (ir_mode && load ##[1:400] serial_out);

endmodule

// ---- hw/dubp_top.sv ----
// Host bus port of a dual-channel serial controller: strobe decode, channel routing and data bus drive.
`timescale 1ns/1ps
module dubp_top #(
  parameter int BIT_CYCLES = dubp_pkg::BIT_CYCLES,
  parameter int IR_CYCLES  = dubp_pkg::IR_CYCLES
) (
  input  wire logic                         mclk,
  input  wire logic                         rst_n,
  input  wire logic                         cs_n,
  input  wire logic                         channel_pick,
  input  wire logic [dubp_pkg::ADDR_W-1:0]  addr,
  input  wire logic                         read_strobe_n,
  input  wire logic                         write_strobe_n,
  input  wire logic [dubp_pkg::DATA_W-1:0]  data_in,
  output logic      [dubp_pkg::DATA_W-1:0]  data_out,
  output logic                              data_oe,
  output logic                              irq_chan_a,
  output logic                              irq_chan_b,
  output logic                              tx_ready_chan_a_n,
  output logic                              tx_ready_chan_b_n,
  output logic                              serial_out_chan_a
);
  import dubp_pkg::*;

  logic              rd_fall;
  logic              rd_rise;
  logic              wr_fall;
  logic              wr_rise;
  logic [DATA_W-1:0] rd_a;
  logic [DATA_W-1:0] rd_b;
  logic              bcast_a;
  logic              bcast_b;
  logic              rd_busy_r;
  logic              rd_busy_nxt;
  logic [DATA_W-1:0] data_out_r;
  logic              wr_busy_r;
  logic              wr_busy_nxt;
  logic [ADDR_W-1:0] wr_addr_r;
  logic              wr_a_r;
  logic              wr_b_r;
  logic              wr_bc_r;
  logic [DATA_W-1:0] wr_data_r;

  dubp_edge u_rd_edge (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .strobe_n (read_strobe_n),
    .fall     (rd_fall),
    .rise     (rd_rise)
  );

  dubp_edge u_wr_edge (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .strobe_n (write_strobe_n),
    .fall     (wr_fall),
    .rise     (wr_rise)
  );

  wire cs_act    = ~cs_n;
  wire pick_a    = (channel_pick == SEL_CHAN_A);
  wire bcast     = bcast_a | bcast_b;
  wire rd_start  = rd_fall && cs_act;
  wire wr_start  = wr_fall && cs_act;
  wire [DATA_W-1:0] rd_byte = pick_a ? rd_a : rd_b;
  wire wr_commit = wr_rise && wr_busy_r;
  wire we_a      = wr_commit && wr_a_r;
  wire we_b      = wr_commit && wr_b_r;
  // The broadcast bit overrides the channel pick for writes only.
  wire tgt_a     = bcast || pick_a;
  wire tgt_b     = bcast || !pick_a;

  // A read ends as soon as the host lets go of either line.
  assign rd_busy_nxt = rd_start || (rd_busy_r && cs_act && !read_strobe_n);
  assign wr_busy_nxt = wr_start || (wr_busy_r && !wr_rise);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rd_busy_r  <= 1'b0;
      data_out_r <= 8'h00;
    end else begin
      rd_busy_r <= rd_busy_nxt;
      if (rd_start) begin
        data_out_r <= rd_byte;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wr_busy_r <= 1'b0;
      wr_addr_r <= 3'h0;
      wr_a_r    <= 1'b0;
      wr_b_r    <= 1'b0;
      wr_bc_r   <= 1'b0;
      wr_data_r <= 8'h00;
    end else begin
      wr_busy_r <= wr_busy_nxt;
      if (wr_start) begin
        wr_addr_r <= addr;
        wr_a_r    <= tgt_a;
        wr_b_r    <= tgt_b;
        wr_bc_r   <= bcast;
      end
      // The byte seen in the last low cycle is the one written at the rise.
      if (!write_strobe_n) begin
        wr_data_r <= data_in;
      end
    end
  end

  dubp_chan #(
    .BIT_CYCLES (BIT_CYCLES),
    .IR_CYCLES  (IR_CYCLES)
  ) u_chan_a (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .wr_en      (we_a),
    .wr_addr    (wr_addr_r),
    .wr_data    (wr_data_r),
    .rd_addr    (addr),
    .rd_data    (rd_a),
    .bcast      (bcast_a),
    .irq        (irq_chan_a),
    .tx_ready_n (tx_ready_chan_a_n),
    .serial_out (serial_out_chan_a)
  );

  // Channel B has no serial pin at this port; its shifter still paces its ready and interrupt status.
  dubp_chan #(
    .BIT_CYCLES (BIT_CYCLES),
    .IR_CYCLES  (IR_CYCLES)
  ) u_chan_b (
    .mclk       (mclk),
    .rst_n      (rst_n),
    .wr_en      (we_b),
    .wr_addr    (wr_addr_r),
    .wr_data    (wr_data_r),
    .rd_addr    (addr),
    .rd_data    (rd_b),
    .bcast      (bcast_b),
    .irq        (irq_chan_b),
    .tx_ready_n (tx_ready_chan_b_n),
    .serial_out ()
  );

  assign data_out = data_out_r;
  // Drive only while the read is live, so the host never sees contention.
  assign data_oe  = rd_busy_r && cs_act && !read_strobe_n;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  chk_read_data_ready: assert property (
    rd_start |=> data_out == $past(rd_byte))
    else $error("Read byte not captured at read strobe fall.");

  chk_read_bus_drive: assert property (
    rd_start ##1 (cs_act && !read_strobe_n) |-> data_oe)
    else $error("Data bus not driven during an active read.");

  chk_bus_release: assert property (
    (cs_n || read_strobe_n) |-> !data_oe)
    else $error("Data bus driven while chip select or read strobe inactive.");

  chk_no_drive_write: assert property (
    (!write_strobe_n && !rd_busy_r) |-> !data_oe)
    else $error("Data bus driven during a write.");

  chk_write_needs_cs: assert property (
    (wr_fall && cs_n && !wr_busy_r) |=> !wr_busy_r)
    else $error("Write started without chip select.");

  chk_route_chan_b: assert property (
    (rd_start && !channel_pick) |=> data_out == $past(rd_b))
    else $error("Channel pick low did not route to channel B.");

  chk_bcast_both: assert property (
    (wr_start && bcast) |=> (wr_a_r && wr_b_r && wr_bc_r))
    else $error("Broadcast write did not reach both channels.");

  chk_write_at_rise: assert property (
    (we_a || we_b) |-> ($past(!write_strobe_n) && write_strobe_n))
    else $error("Register write not aligned to write strobe rise.");

  cov_read_a: cover property (rd_start && pick_a ##1 data_oe);
  cov_write_b: cover property (wr_commit && !wr_a_r && wr_b_r);
  cov_bcast: cover property (wr_commit && wr_bc_r);
  cov_read_b: cover property (rd_start && !pick_a ##[1:4] rd_rise);

endmodule

// ---- testbench/dubp_host_model.sv ----
// Host processor model that drives the asynchronous register bus of the port.
`timescale 1ns/1ps
module dubp_host_model (
  input  wire logic       mclk,
  output logic            cs_n,
  output logic            channel_pick,
  output logic [2:0]      addr,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic [7:0]      data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe
);
  logic       drive_r;
  logic [7:0] wr_byte;
  logic [7:0] idle_pat;

  // A released bus shows a moving pattern, so stale write data never passes for a read.
  assign data_in = drive_r ? wr_byte : idle_pat;

  initial begin
    cs_n = 1'h1;
    channel_pick = 1'h0;
    addr = 3'h0;
    read_strobe_n = 1'h1;
    write_strobe_n = 1'h1;
    drive_r = 1'h0;
    wr_byte = 8'h00;
    idle_pat = 8'h5a;
  end

  always @(negedge mclk) begin
    idle_pat <= {idle_pat[6:0], ~idle_pat[7]};
  end

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d, input logic sel_n);
    @(negedge mclk);
    cs_n <= sel_n;
    channel_pick <= ch;
    addr <= a;
    wr_byte <= d;
    drive_r <= 1'h1;
    write_strobe_n <= 1'h0;
    repeat (2) @(negedge mclk);
    write_strobe_n <= 1'h1;
    @(negedge mclk);
    cs_n <= 1'h1;
    drive_r <= 1'h0;
    @(negedge mclk);
  endtask

  task automatic rd(input logic ch, input logic [2:0] a, input logic sel_n, output logic [7:0] d,
                    output logic oe);
    @(negedge mclk);
    cs_n <= sel_n;
    channel_pick <= ch;
    addr <= a;
    read_strobe_n <= 1'h0;
    repeat (2) @(negedge mclk);
    d = data_oe ? data_out : idle_pat;
    oe = data_oe;
    read_strobe_n <= 1'h1;
    cs_n <= 1'h1;
    @(negedge mclk);
  endtask
endmodule

// ---- testbench/test_dual_uart_host_bus_port.sv ----
// Self-checking bench for the dual-channel host bus port.
`timescale 1ns/1ps
module test_dual_uart_host_bus_port;
  import dubp_pkg::*;
  localparam int BC  = 4;
  localparam int IRC = 1;
  logic       mclk;
  logic       rst_n;
  logic       cs_n;
  logic       channel_pick;
  logic [2:0] addr;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic [7:0] data_in;
  logic [7:0] data_out;
  logic       data_oe;
  logic       irq_chan_a;
  logic       irq_chan_b;
  logic       tx_ready_chan_a_n;
  logic       tx_ready_chan_b_n;
  logic       serial_out_chan_a;
  logic [7:0] exp_r [2][8];
  logic       seen_busy_a;
  logic       seen_busy_b;
  logic [7:0] rd_d;
  logic       rd_oe;
  logic [7:0] bytes [3];
  int         hi_cnt;
  int         num_errors;
  int         compares;

  dubp_top #(.BIT_CYCLES(BC), .IR_CYCLES(IRC)) u_dubp_top (
    .mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .channel_pick(channel_pick), .addr(addr),
    .read_strobe_n(read_strobe_n), .write_strobe_n(write_strobe_n), .data_in(data_in),
    .data_out(data_out), .data_oe(data_oe), .irq_chan_a(irq_chan_a), .irq_chan_b(irq_chan_b),
    .tx_ready_chan_a_n(tx_ready_chan_a_n), .tx_ready_chan_b_n(tx_ready_chan_b_n),
    .serial_out_chan_a(serial_out_chan_a));

  dubp_host_model u_dubp_host_model (
    .mclk(mclk), .cs_n(cs_n), .channel_pick(channel_pick), .addr(addr), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n), .data_in(data_in), .data_out(data_out), .data_oe(data_oe));

  initial begin
    mclk = 1'h0;
    forever #2 mclk = ~mclk;
  end

  // The ready pulse lasts about one cycle, so it is caught by sticky flags.
  always @(posedge mclk) begin
    if (tx_ready_chan_a_n === 1'h1) seen_busy_a <= 1'h1;
    if (tx_ready_chan_b_n === 1'h1) seen_busy_b <= 1'h1;
    if (serial_out_chan_a === 1'h1) hi_cnt <= hi_cnt + 1;
  end

  function automatic int ir_highs(input logic [7:0] d);
    int n;
    n = 1;
    for (int i = 0; i < 8; i++) n += (d[i] == 1'h0);
    return n * IRC;
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want) begin
      num_errors++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic stop_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic wr(input logic ch, input logic [2:0] a, input logic [7:0] d);
    logic bc;
    bc = exp_r[0][ALTF_IDX][ALTF_BCAST_BIT] | exp_r[1][ALTF_IDX][ALTF_BCAST_BIT];
    u_dubp_host_model.wr(ch, a, d, 1'h0);
    exp_r[ch][a] = d;
    if (bc) exp_r[~ch][a] = d;
  endtask

  task automatic rd_chk(input logic ch, input logic [2:0] a);
    u_dubp_host_model.rd(ch, a, 1'h0, rd_d, rd_oe);
    check(rd_oe, 1'h1);
    check(rd_d, exp_r[ch][a]);
    check(data_oe, 1'h0);
  endtask

  task automatic send_a(input logic [7:0] d, input logic ir);
    int k;
    seen_busy_a = 1'h0;
    hi_cnt = 0;
    fork
      wr(1'h1, HOLD_IDX, d);
      if (!ir) begin
        k = 0;
        while (serial_out_chan_a !== 1'h0 && k < 40) begin
          @(negedge mclk);
          k++;
        end
        repeat (BC / 2) @(negedge mclk);
        check(serial_out_chan_a, 1'h0);
        for (int i = 0; i < 8; i++) begin
          repeat (BC) @(negedge mclk);
          check(serial_out_chan_a, d[i]);
        end
        repeat (BC) @(negedge mclk);
        check(serial_out_chan_a, 1'h1);
      end
    join
    repeat (12 * BC) @(negedge mclk);
    check(seen_busy_a, 1'h1);
    check(tx_ready_chan_a_n, 1'h0);
    check(irq_chan_a, exp_r[1][INTEN_IDX][INTEN_TXE_BIT]);
    check(serial_out_chan_a, !ir);
    if (ir) check(8'(hi_cnt), 8'(ir_highs(d)));
  endtask

  initial begin
    #200000;
    num_errors++;
    stop_test();
  end

  initial begin
    logic       ch;
    logic [2:0] a;
    logic [7:0] d;
    rst_n = 1'h0;
    seen_busy_a = 1'h0;
    seen_busy_b = 1'h0;
    hi_cnt = 0;
    num_errors = 0;
    compares = 0;
    void'($urandom(22489));
    foreach (exp_r[i, j]) exp_r[i][j] = REG_RST;
    repeat (10) @(negedge mclk);
    check(data_oe, 1'h0);
    check({irq_chan_a, irq_chan_b, tx_ready_chan_a_n, tx_ready_chan_b_n}, 4'h0);
    check(serial_out_chan_a, 1'h1);
    rst_n = 1'h1;
    repeat (2) @(negedge mclk);
    for (int i = 0; i < 60; i++) begin
      ch = 1'($urandom);
      a = 3'($urandom_range(7, 1));
      d = 8'($urandom);
      if (a == ALTF_IDX) d[ALTF_BCAST_BIT] = 1'h0;
      wr(ch, a, d);
      rd_chk(ch, a);
      rd_chk(~ch, a);
      check(irq_chan_a, exp_r[1][INTEN_IDX][INTEN_TXE_BIT]);
      check(irq_chan_b, exp_r[0][INTEN_IDX][INTEN_TXE_BIT]);
      check(serial_out_chan_a, !exp_r[1][MODEM_IDX][MODEM_IR_BIT]);
    end
    // Strobes with chip select high must neither write nor drive the bus.
    u_dubp_host_model.wr(1'h1, 3'h3, ~exp_r[1][3], 1'h1);
    rd_chk(1'h1, 3'h3);
    u_dubp_host_model.rd(1'h1, 3'h3, 1'h1, rd_d, rd_oe);
    check(rd_oe, 1'h0);
    wr(1'h1, ALTF_IDX, 8'h01);
    wr(1'h0, 3'h5, 8'h3c);
    rd_chk(1'h1, 3'h5);
    wr(1'h0, ALTF_IDX, 8'h00);
    wr(1'h0, 3'h6, 8'hc3);
    rd_chk(1'h1, 3'h6);
    rd_chk(1'h1, ALTF_IDX);
    wr(1'h1, INTEN_IDX, 8'h02);
    wr(1'h0, INTEN_IDX, 8'h02);
    bytes[0] = 8'h00;
    bytes[1] = 8'hff;
    bytes[2] = 8'($urandom);
    for (int m = 0; m < 2; m++) begin
      wr(1'h1, MODEM_IDX, m ? 8'h40 : 8'h00);
      check(serial_out_chan_a, !m[0]);
      for (int b = 0; b < 3; b++) send_a(bytes[b], m[0]);
    end
    seen_busy_b = 1'h0;
    wr(1'h0, HOLD_IDX, 8'ha5);
    repeat (12 * BC) @(negedge mclk);
    check(seen_busy_b, 1'h1);
    check(tx_ready_chan_b_n, 1'h0);
    check(irq_chan_b, 1'h1);
    stop_test();
  end
endmodule
